//--- scfp_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module scfp_assertions #(
	parameter [7:0] CUR_MIN   = 8'h04,
	parameter [7:0] CUR_MAX   = 8'h19,
	parameter [7:0] MAX_BLOCK = 8'h01
) (
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Bus request side.
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	// Status.
	input wire logic        dataRegSel,
	input wire logic        intrq,
	input wire logic        busy,
	input wire logic        wideAccessInd,
	input wire logic        eightBitMode,
	input wire logic        multEnable,
	input wire logic [7:0]  blockCount,
	input wire logic [7:0]  currentLimit,
	input wire logic        sleepMode
);
	wire       cmdTake;
	wire [7:0] code;
	wire       toSleep;
	assign cmdTake = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0]
		& (wb_adr_i[5:2] == 4'h7) & ~busy;
	assign code = wb_dat_i[7:0];
	assign toSleep = code inside {8'h99, 8'hE6, 8'h96, 8'hE2, 8'h94, 8'hE0};
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
	a_ackOne: assert property (p_ackOne)
		else $error("ack held too long");
	property p_wide8; eightBitMode |-> !wideAccessInd;
	endproperty
	a_wide8: assert property (p_wide8)
		else $error("wide indicator in 8-bit mode");
	property p_wide16;
		!eightBitMode && !$past(eightBitMode) && !$past(sys_rst)
		|-> wideAccessInd == $past(dataRegSel);
	endproperty
	a_wide16: assert property (p_wide16)
		else $error("wide indicator wrong in 16-bit mode");
	property p_cmdBusy; cmdTake |=> busy; endproperty
	a_cmdBusy: assert property (p_cmdBusy)
		else $error("busy not set on command");
	property p_busyLen; $rose(busy) |=> busy ##1 !busy; endproperty
	a_busyLen: assert property (p_busyLen)
		else $error("busy length wrong");
	property p_done; $fell(busy) |-> intrq; endproperty
	a_done: assert property (p_done)
		else $error("no interrupt at completion");
	property p_sleep; cmdTake && toSleep |-> ##3 sleepMode && !busy; endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep not entered");
	property p_wake; cmdTake && !toSleep && sleepMode |-> ##3 !sleepMode;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake on command");
	property p_mult;
		multEnable |-> blockCount != 8'h00 && blockCount <= MAX_BLOCK;
	endproperty
	a_mult: assert property (p_mult)
		else $error("multiple enabled with bad count");
	property p_cur;
		currentLimit >= CUR_MIN && currentLimit <= CUR_MAX;
	endproperty
	a_cur: assert property (p_cur)
		else $error("current limit out of range");
endmodule
`default_nettype wire

//--- scfp_cmd_ctrl.v
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "scfp_defines.vh"

module scfp_cmd_ctrl #(
	parameter       EXT_POWER   = 1'b1,
	parameter [7:0] CUR_MIN     = 8'h04,
	parameter [7:0] CUR_MAX     = 8'h19,
	parameter [7:0] MAX_BLOCK   = 8'h01,
	parameter       TW          = 20,
	parameter       IDLE_CYCLES = `SCFP_IDLE_MS * `SCFP_CLK_KHZ
) (
	// Clock and reset.
	input  wire        mclk,
	input  wire        sys_rst,
	// Wishbone slave.
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Host side data strobe.
	input  wire        dataRegSel,
	// Status outputs.
	output reg         intrq,
	output reg         busy,
	output reg         wideAccessInd,
	output reg         eightBitMode,
	output reg         pl1Enable,
	output reg         multEnable,
	output reg  [7:0]  blockCount,
	output reg  [7:0]  currentLimit,
	output reg         sleepMode
);

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_EXEC = 2'b01;
	localparam [1:0] ST_DONE = 2'b10;

	localparam integer  IDLE_END  = IDLE_CYCLES - 1;
	localparam [TW-1:0] IDLE_LAST = IDLE_END[TW-1:0];

	reg [1:0]    state_r;
	reg [7:0]    featureReg_r;
	reg [7:0]    secCnt_r;
	reg [7:0]    secNum_r;
	reg [7:0]    cylLo_r;
	reg [7:0]    cylHi_r;
	reg [7:0]    cdh_r;
	reg [7:0]    cmd_r;
	reg [7:0]    errReg_r;
	reg          errFlag_r;
	reg          lookAhead_r;
	reg          long4_r;
	reg          porRestore_r;
	reg          srstLvl_r;
	reg [TW-1:0] idleCnt_r;

	wire                  req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [`SCFP_IDX_W-1:0] idx    = wb_adr_i[5:2];
	wire                  wrStb   = req & wb_we_i & wb_sel_i[0];
	wire                  rdStb   = req & ~wb_we_i;
	wire [7:0]            wrByte  = wb_dat_i[7:0];
	wire                  cmdWr   = wrStb & (idx == `SCFP_IDX_CMD) & ~busy;
	wire                  ctrlWr  = wrStb & (idx == `SCFP_IDX_CTRL);
	wire                  srstNow = ctrlWr & wrByte[`SCFP_CT_SRST] & ~srstLvl_r;
	wire                  tfWr    = wrStb & ~busy;
	wire                  goEight = (state_r == ST_EXEC) & ~srstNow &
		(cmd_r == `SCFP_CMD_SETFEAT) & (featureReg_r == `SCFP_FT_8BIT_ON);

	// Decodes the feature codes that the device accepts.
	function featKnown;
		input [7:0] f;
		begin
			case (f)
			`SCFP_FT_8BIT_ON, `SCFP_FT_8BIT_OFF,
			`SCFP_FT_PL1_ON, `SCFP_FT_PL1_OFF,
			`SCFP_FT_NOLA, `SCFP_FT_LONG4,
			`SCFP_FT_NOPOR, `SCFP_FT_POR,
			`SCFP_FT_NOP_A, `SCFP_FT_NOP_B, `SCFP_FT_COMPAT,
			`SCFP_FT_CURRENT: featKnown = 1'b1;
			default: featKnown = 1'b0;
			endcase
		end
	endfunction

	// Clamps a requested current into the supported window.
	function [7:0] clampCur;
		input [7:0] v;
		begin
			if (v < CUR_MIN) begin
				clampCur = CUR_MIN;
			end else if (v > CUR_MAX) begin
				clampCur = CUR_MAX;
			end else begin
				clampCur = v;
			end
		end
	endfunction

	// Register read mux.
	reg [7:0] rdByte;
	always @* begin
		rdByte = 8'h00;
		case (idx)
		`SCFP_IDX_FEATURE: rdByte = errReg_r;
		`SCFP_IDX_SECCNT:  rdByte = secCnt_r;
		`SCFP_IDX_SECNUM:  rdByte = secNum_r;
		`SCFP_IDX_CYLLO:   rdByte = cylLo_r;
		`SCFP_IDX_CYLHI:   rdByte = cylHi_r;
		`SCFP_IDX_CDH:     rdByte = cdh_r;
		`SCFP_IDX_CMD: begin
			rdByte[`SCFP_ST_BUSY]  = busy;
			rdByte[`SCFP_ST_READY] = ~busy;
			rdByte[`SCFP_ST_ERR]   = errFlag_r;
		end
		`SCFP_IDX_CTRL: rdByte[`SCFP_CT_SRST] = srstLvl_r;
		`SCFP_IDX_MODE: begin
			rdByte[`SCFP_MD_8BIT]      = eightBitMode;
			rdByte[`SCFP_MD_PL1]       = pl1Enable;
			rdByte[`SCFP_MD_LOOKAHEAD] = lookAhead_r;
			rdByte[`SCFP_MD_LONG4]     = long4_r;
			rdByte[`SCFP_MD_PORREST]   = porRestore_r;
			rdByte[`SCFP_MD_MULTEN]    = multEnable;
			rdByte[`SCFP_MD_SLEEP]     = sleepMode;
		end
		default: rdByte = 8'h00;
		endcase
	end

	// Bus answer: one wait state, unmapped indices read zero and ack.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (rdStb) begin
				wb_dat_o <= {24'h000000, rdByte};
			end
		end
	end

	// Indicator is registered from the host strobe, gated by the width.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wideAccessInd <= 1'b0;
		end else begin
			// Masking on entry keeps the first 8-bit cycle clean as well.
			wideAccessInd <= dataRegSel & ~eightBitMode & ~goEight;
		end
	end

	// Inactivity timer; any bus request restarts it.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			idleCnt_r <= {TW{1'b0}};
		end else if (req | busy | sleepMode) begin
			idleCnt_r <= {TW{1'b0}};
		end else if (idleCnt_r != IDLE_LAST) begin
			idleCnt_r <= idleCnt_r + {{(TW-1){1'b0}}, 1'b1};
		end
	end

	// Command engine and settings.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r      <= ST_IDLE;
			busy         <= 1'b0;
			intrq        <= 1'b0;
			featureReg_r <= 8'h00;
			secCnt_r     <= 8'h00;
			secNum_r     <= 8'h00;
			cylLo_r      <= 8'h00;
			cylHi_r      <= 8'h00;
			cdh_r        <= 8'h00;
			cmd_r        <= 8'h00;
			errReg_r     <= 8'h00;
			errFlag_r    <= 1'b0;
			srstLvl_r    <= 1'b0;
			eightBitMode <= 1'b0;
			pl1Enable    <= EXT_POWER;
			lookAhead_r  <= 1'b0;
			long4_r      <= 1'b1;
			porRestore_r <= 1'b1;
			multEnable   <= 1'b0;
			blockCount   <= 8'h00;
			currentLimit <= CUR_MAX;
			sleepMode    <= 1'b0;
		end else begin
			if (ctrlWr) begin
				srstLvl_r <= wrByte[`SCFP_CT_SRST];
			end
			if (rdStb & (idx == `SCFP_IDX_CMD)) begin
				intrq <= 1'b0;
			end
			if (tfWr) begin
				case (idx)
				`SCFP_IDX_FEATURE: featureReg_r <= wrByte;
				`SCFP_IDX_SECCNT:  secCnt_r <= wrByte;
				`SCFP_IDX_SECNUM:  secNum_r <= wrByte;
				`SCFP_IDX_CYLLO:   cylLo_r <= wrByte;
				`SCFP_IDX_CYLHI:   cylHi_r <= wrByte;
				`SCFP_IDX_CDH:     cdh_r <= wrByte;
				default: ;
				endcase
			end
			if (idleCnt_r == IDLE_LAST) begin
				sleepMode <= 1'b1;
			end
			if (srstNow) begin
				// Soft reset abandons any command in flight.
				state_r   <= ST_IDLE;
				busy      <= 1'b0;
				intrq     <= 1'b0;
				errFlag_r <= 1'b0;
				errReg_r  <= 8'h00;
				sleepMode <= 1'b0;
				if (porRestore_r) begin
					eightBitMode <= 1'b0;
					pl1Enable    <= EXT_POWER;
					lookAhead_r  <= 1'b0;
					long4_r      <= 1'b1;
					multEnable   <= 1'b0;
					blockCount   <= 8'h00;
					currentLimit <= CUR_MAX;
				end
			end else begin
				case (state_r)
				ST_IDLE: begin
					if (cmdWr) begin
						cmd_r     <= wrByte;
						busy      <= 1'b1;
						intrq     <= 1'b0;
						sleepMode <= 1'b0;
						errFlag_r <= 1'b0;
						errReg_r  <= 8'h00;
						state_r   <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state_r <= ST_DONE;
					case (cmd_r)
					`SCFP_CMD_SETFEAT: begin
						if (!featKnown(featureReg_r)) begin
							errFlag_r <= 1'b1;
							errReg_r[`SCFP_ER_ABORT] <= 1'b1;
						end
						case (featureReg_r)
						`SCFP_FT_8BIT_ON:  eightBitMode <= 1'b1;
						`SCFP_FT_8BIT_OFF: eightBitMode <= 1'b0;
						`SCFP_FT_PL1_ON:   pl1Enable <= 1'b1;
						`SCFP_FT_PL1_OFF:  pl1Enable <= 1'b0;
						`SCFP_FT_NOLA:     lookAhead_r <= 1'b0;
						`SCFP_FT_LONG4:    long4_r <= 1'b1;
						`SCFP_FT_NOPOR:    porRestore_r <= 1'b0;
						`SCFP_FT_POR:      porRestore_r <= 1'b1;
						`SCFP_FT_CURRENT: begin
							currentLimit <= clampCur(secCnt_r);
							cylLo_r      <= CUR_MIN;
							cylHi_r      <= CUR_MAX;
						end
						default: ;
						endcase
					end
					`SCFP_CMD_SETMULT: begin
						if (secCnt_r == 8'h00) begin
							multEnable <= 1'b0;
						end else if (secCnt_r <= MAX_BLOCK) begin
							blockCount <= secCnt_r;
							multEnable <= 1'b1;
						end else begin
							multEnable <= 1'b0;
							errFlag_r  <= 1'b1;
							errReg_r[`SCFP_ER_ABORT] <= 1'b1;
						end
					end
					`SCFP_CMD_SLEEP_A, `SCFP_CMD_SLEEP_B: begin
						sleepMode <= 1'b1;
					end
					`SCFP_CMD_STBY_A, `SCFP_CMD_STBY_B: begin
						sleepMode <= 1'b1;
					end
					`SCFP_CMD_STBYI_A, `SCFP_CMD_STBYI_B: begin
						sleepMode <= 1'b1;
					end
					default: begin
						// Commands outside this block are refused.
						errFlag_r <= 1'b1;
						errReg_r[`SCFP_ER_ABORT] <= 1'b1;
					end
					endcase
				end
				ST_DONE: begin
					busy    <= 1'b0;
					intrq   <= 1'b1;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

//--- scfp_defines.vh
`ifndef SCFP_DEFINES_VH
`define SCFP_DEFINES_VH

// Register indices; byte address is four times the index.
`define SCFP_IDX_W        4
`define SCFP_IDX_DATA     4'h0
`define SCFP_IDX_FEATURE  4'h1
`define SCFP_IDX_SECCNT   4'h2
`define SCFP_IDX_SECNUM   4'h3
`define SCFP_IDX_CYLLO    4'h4
`define SCFP_IDX_CYLHI    4'h5
`define SCFP_IDX_CDH      4'h6
`define SCFP_IDX_CMD      4'h7
`define SCFP_IDX_CTRL     4'h8
`define SCFP_IDX_MODE     4'h9

// Command codes.
`define SCFP_CMD_SETFEAT  8'hEF
`define SCFP_CMD_SETMULT  8'hC6
`define SCFP_CMD_SLEEP_A  8'h99
`define SCFP_CMD_SLEEP_B  8'hE6
`define SCFP_CMD_STBY_A   8'h96
`define SCFP_CMD_STBY_B   8'hE2
`define SCFP_CMD_STBYI_A  8'h94
`define SCFP_CMD_STBYI_B  8'hE0

// Feature codes.
`define SCFP_FT_8BIT_ON   8'h01
`define SCFP_FT_PL1_ON    8'h0A
`define SCFP_FT_NOLA      8'h55
`define SCFP_FT_NOPOR     8'h66
`define SCFP_FT_NOP_A     8'h69
`define SCFP_FT_8BIT_OFF  8'h81
`define SCFP_FT_PL1_OFF   8'h8A
`define SCFP_FT_NOP_B     8'h96
`define SCFP_FT_COMPAT    8'h97
`define SCFP_FT_CURRENT   8'h9A
`define SCFP_FT_LONG4     8'hBB
`define SCFP_FT_POR       8'hCC

// Status, error and control bit positions.
`define SCFP_ST_BUSY      7
`define SCFP_ST_READY     6
`define SCFP_ST_ERR       0
`define SCFP_ER_ABORT     2
`define SCFP_CT_SRST      2

// Mode register bit positions.
`define SCFP_MD_8BIT      0
`define SCFP_MD_PL1       1
`define SCFP_MD_LOOKAHEAD 2
`define SCFP_MD_LONG4     3
`define SCFP_MD_PORREST   4
`define SCFP_MD_MULTEN    5
`define SCFP_MD_SLEEP     6

// Timing.
`define SCFP_IDLE_MS      5
`define SCFP_CLK_KHZ      100000

`endif

//--- scfp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module scfp_host_model (
	// Clock.
	input  wire logic        mclk,
	// Bus master.
	output var  logic        cyc,
	output var  logic        stb,
	output var  logic        we,
	output var  logic [5:0]  adr,
	output var  logic [3:0]  sel,
	output var  logic [31:0] dat,
	input  wire logic        ack,
	input  wire logic [31:0] rdat
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 6'h00;
		sel = 4'h0;
		dat = 32'h0;
	end
	// Idle gaps add zero to three cycles; at least one idle cycle always separates requests.
	task automatic xfer(input w, input [3:0] x, input [7:0] d,
		input int gap, output [7:0] q);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {x, 2'b00};
		sel <= 4'h1;
		dat <= {24'h0, d};
		// Only the bench's watchdog may end the wait for an answer.
		do
			@(posedge mclk);
		while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
		// Released lines change so that no stale value is trusted.
		we <= ~w;
		dat <= ~dat;
	endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
	logic        mclk = 1'b0;
	logic        sysRst;
	logic        dataRegSel = 1'b0;
	wire         cyc, stb, we, ack, intrq, busy, eight, pl1, multEn, slp;
	wire         wide;
	wire  [3:0]  sel;
	wire  [5:0]  adr;
	wire  [31:0] dat, rdat;
	wire  [7:0]  blk, cur;
	integer      fails, checks, seed, i;
	logic [7:0]  q, m, f, v;
	logic [7:0]  tbl [12] = '{8'h01, 8'h0A, 8'h55, 8'h66, 8'h69, 8'h81,
		8'h8A, 8'h96, 8'h97, 8'h9A, 8'hBB, 8'hCC};
	logic [7:0]  sl [6] = '{8'h99, 8'hE6, 8'h96, 8'hE2, 8'h94, 8'hE0};
	scfp_host_model u_host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .dat(dat), .ack(ack), .rdat(rdat));
	scfp_cmd_ctrl #(.IDLE_CYCLES(50)) u_dut (.mclk(mclk), .sys_rst(sysRst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dataRegSel(dataRegSel), .intrq(intrq), .busy(busy),
		.wideAccessInd(wide), .eightBitMode(eight), .pl1Enable(pl1),
		.multEnable(multEn), .blockCount(blk), .currentLimit(cur),
		.sleepMode(slp));
	always #5 mclk = ~mclk;
	always @(posedge mclk) dataRegSel <= ^$random(seed);
	function automatic [7:0] nextMode(input [7:0] m, input [7:0] f);
		nextMode = m;
		case (f)
			8'h01: nextMode[0] = 1'b1;
			8'h81: nextMode[0] = 1'b0;
			8'h0A: nextMode[1] = 1'b1;
			8'h8A: nextMode[1] = 1'b0;
			8'h55: nextMode[2] = 1'b0;
			8'hBB: nextMode[3] = 1'b1;
			8'h66: nextMode[4] = 1'b0;
			8'hCC: nextMode[4] = 1'b1;
			default: ;
		endcase
	endfunction
	task automatic bus(input w, input [3:0] x, input [7:0] d);
		u_host.xfer(w, x, d, $random(seed) & 3, q);
	endtask
	task automatic cmd(input [7:0] c, input err);
		bus(1'b1, 4'h7, c);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("intrq", 1'b1, intrq)
		bus(1'b0, 4'h7, 8'h00);
		`CHK("status", {1'b0, err}, {q[7], q[0]})
	endtask
	task automatic feat(input [7:0] fc, input [7:0] sc, input err);
		bus(1'b1, 4'h1, fc);
		bus(1'b1, 4'h2, sc);
		cmd(8'hEF, err);
	endtask
	task automatic report_and_stop;
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#300000;
		fails++;
		report_and_stop;
	end
	initial begin
		seed = 32'h745da2cb;
		fails = 0;
		checks = 0;
		sysRst = 1'b1;
		repeat (3) @(posedge mclk);
		sysRst <= 1'b0;
		bus(1'b0, 4'h9, 8'h00);
		`CHK("modeRst", 8'h1A, q)
		`CHK("pl1Rst", 1'b1, pl1)
		`CHK("curRst", 8'h19, cur)
		m = 8'h1A;
		for (i = 0; i < 40; i++) begin
			f = i < 12 ? tbl[i] : i[0] ? $random(seed) : tbl[$unsigned(seed) % 12];
			v = $random(seed);
			if (f inside {tbl}) begin
				feat(f, v, 1'b0);
				m = nextMode(m, f);
			end else begin
				feat(f, v, 1'b1);
				bus(1'b0, 4'h1, 8'h00);
				`CHK("abort", 1'b1, q[2])
			end
			bus(1'b0, 4'h9, 8'h00);
			`CHK("mode", m[4:0], q[4:0])
			`CHK("wide8", 1'b0, m[0] & wide)
			if (f == 8'h9A) begin
				`CHK("limit", v < 8'h04 ? 8'h04 : v > 8'h19 ? 8'h19 : v, cur)
				bus(1'b0, 4'h4, 8'h00);
				`CHK("cylLo", 8'h04, q)
				bus(1'b0, 4'h5, 8'h00);
				`CHK("cylHi", 8'h19, q)
			end
		end
		feat(8'hCC, 8'h00, 1'b0);
		for (i = 0; i < 5; i++) begin
			v = i < 4 ? i[7:0] : $random(seed);
			bus(1'b1, 4'h2, v);
			cmd(8'hC6, v > 8'h01);
			`CHK("multEn", v == 8'h01, multEn)
			if (v == 8'h01)
				`CHK("blk", 8'h01, blk)
		end
		for (i = 0; i < 2; i++) begin
			if (i == 1)
				feat(8'h66, 8'h00, 1'b0);
			bus(1'b1, 4'h2, 8'h01);
			cmd(8'hC6, 1'b0);
			bus(1'b1, 4'h8, 8'h04);
			bus(1'b1, 4'h8, 8'h00);
			`CHK("srstMult", i[0], multEn)
			bus(1'b0, 4'h9, 8'h00);
			`CHK("srstMode", i[0] ? 5'h0A : 5'h1A, q[4:0])
		end
		cmd(8'h00, 1'b1);
		sysRst <= 1'b1;
		repeat (3) @(posedge mclk);
		sysRst <= 1'b0;
		bus(1'b0, 4'h9, 8'h00);
		`CHK("hwRstMode", 8'h1A, q)
		`CHK("hwRstMult", 1'b0, multEn)
		for (i = 0; i < 6; i++) begin
			cmd(sl[i], 1'b0);
			`CHK("sleep", 1'b1, slp)
			feat(8'h69, 8'h00, 1'b0);
			`CHK("wake", 1'b0, slp)
		end
		repeat (40) @(posedge mclk);
		#1;
		`CHK("awake", 1'b0, slp)
		repeat (20) @(posedge mclk);
		#1;
		`CHK("idleSleep", 1'b1, slp)
		report_and_stop;
	end
endmodule
bind scfp_cmd_ctrl scfp_assertions #(.CUR_MIN(CUR_MIN), .CUR_MAX(CUR_MAX),
	.MAX_BLOCK(MAX_BLOCK)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .dataRegSel(dataRegSel), .intrq(intrq),
	.busy(busy), .wideAccessInd(wideAccessInd), .eightBitMode(eightBitMode),
	.multEnable(multEnable), .blockCount(blockCount),
	.currentLimit(currentLimit), .sleepMode(sleepMode));
`default_nettype wire
